/* File: hdl/kam_monitor.sv */
// receive-side k1/k2 protection byte alarm monitor
// Operation
// - byte failure or invalid code raises failure
// - ring mode: invalid ring pair raises default
// - unused mode code, three identical frames
// - irrelevant code, three identical frames
// - request unfit for ring state, three frames
// - extra-traffic received but not sourced
// - external switch suppresses improper code
// - three non-identical frames raise inconsistent
// - protect received while working expected: mismatch
// - mismatch only on bidirectional linear 1+1
// - crossed fibers, working active: no mismatch
// - mismatch major service-affecting; others minor
`timescale 1ns/100ps
`include "kam_defines.svh"
module kam_monitor (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic frame_strobe,
	input wire kam_pkg::kam_kbytes_t rx_kbytes,
	input wire logic rx_byte_fail,
	input wire kam_pkg::kam_prot_t prot_mode,
	input wire logic bidirectional,
	input wire logic expect_working,
	input wire logic working_active,
	input wire logic tx_sourcing_et,
	input wire logic ext_switch,
	output logic channel_byte_failure_alarm,
	output logic default_kbyte_alarm,
	output logic improper_code_alarm,
	output logic inconsistent_aps_alarm,
	output logic channel_mismatch_alarm,
	output kam_pkg::kam_sev_t mismatch_severity,
	output kam_pkg::kam_sev_t minor_severity
);
	// ****************************************
	// frame persistence
	// ****************************************
	logic stable;
	logic inconsistent;

	kam_persist u_persist (
		.ref_clk(ref_clk),
		.rst_b(rst_b),
		.frame_strobe(frame_strobe),
		.kbytes(rx_kbytes),
		.stable(stable),
		.inconsistent(inconsistent)
	);

	// ****************************************
	// code decode
	// ****************************************
	// frame_strobe is assumed same-domain; persistence and the held k bytes update on the same strobe
	kam_pkg::kam_kbytes_t held;
	logic [3:0] req;
	logic [2:0] mode;
	logic is_ring;
	logic bad_code;
	logic unused_code;
	logic irrelevant_code;
	logic unfit_ring;
	logic et_unsourced;
	logic bad_ring_pair;
	logic protect_rx;

	always_comb begin
		req = held.k1[7:4];
		mode = held.k2[`KAM_K2_MODE_MSB:`KAM_K2_MODE_LSB];
		is_ring = (prot_mode == kam_pkg::KAM_PROT_RING_2F) ||
			(prot_mode == kam_pkg::KAM_PROT_RING_4F);
		bad_code = (req == `KAM_REQ_INVALID);
		unused_code = (mode == `KAM_MODE_UNUSED0) || (mode == `KAM_MODE_RSVD);
		// a request with no channel, or a channel named with no request
		irrelevant_code = (req == `KAM_REQ_NONE) != (held.k1[3:0] == 4'h0);
		unfit_ring = (prot_mode == kam_pkg::KAM_PROT_RING_2F) &&
			(req == `KAM_REQ_SPAN_SF || req == `KAM_REQ_SPAN_SD ||
			req == `KAM_REQ_EXER_SPAN || req == `KAM_REQ_FS_SPAN);
		et_unsourced = (mode == `KAM_MODE_ET) && !tx_sourcing_et;
		bad_ring_pair = bad_code || unused_code;
		protect_rx = held.k2[7:4] != 4'h0;
	end

	// ****************************************
	// alarm registers
	// ****************************************
	logic next_fail;
	logic next_dflt;
	logic next_imp;
	logic next_incon;
	logic next_mism;
	kam_pkg::kam_kbytes_t next_held;

	always_comb begin
		next_held = frame_strobe ? rx_kbytes : held;
		next_fail = rx_byte_fail || (stable && bad_code);
		next_dflt = is_ring && stable && bad_ring_pair;
		next_imp = stable && !ext_switch &&
			(unused_code || irrelevant_code || unfit_ring || et_unsourced);
		next_incon = inconsistent;
		next_mism = stable && (prot_mode == kam_pkg::KAM_PROT_LIN_1P1) && bidirectional &&
			expect_working && protect_rx && !working_active;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			held <= '0;
			channel_byte_failure_alarm <= 1'b0;
			default_kbyte_alarm <= 1'b0;
			improper_code_alarm <= 1'b0;
			inconsistent_aps_alarm <= 1'b0;
			channel_mismatch_alarm <= 1'b0;
			mismatch_severity <= '0;
			minor_severity <= '0;
		end else begin
			held <= next_held;
			channel_byte_failure_alarm <= next_fail;
			default_kbyte_alarm <= next_dflt;
			improper_code_alarm <= next_imp;
			inconsistent_aps_alarm <= next_incon;
			channel_mismatch_alarm <= next_mism;
			mismatch_severity <= '{`KAM_SEV_MAJOR, 1'b1};
			minor_severity <= '{`KAM_SEV_MINOR, 1'b0};
		end
	end

	// ****************************************
	// checks
	// ****************************************
	AST_FAIL_ON_PIN: assert property (@(posedge ref_clk) disable iff (!rst_b)
		rx_byte_fail |=> channel_byte_failure_alarm)
		else $error("byte failure not flagged");
	AST_DFLT_RING_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!is_ring |=> !default_kbyte_alarm)
		else $error("default k alarm outside ring");
	AST_IMP_NEEDS_STABLE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!stable |=> !improper_code_alarm)
		else $error("improper code without three frames");
	AST_IMP_ET: assert property (@(posedge ref_clk) disable iff (!rst_b)
		stable && !ext_switch && mode == `KAM_MODE_ET && !tx_sourcing_et
		|=> improper_code_alarm)
		else $error("unsourced extra traffic not flagged");
	AST_IMP_SUPPRESS: assert property (@(posedge ref_clk) disable iff (!rst_b)
		ext_switch |=> !improper_code_alarm)
		else $error("improper code under external switch");
	AST_INCON_FOLLOW: assert property (@(posedge ref_clk) disable iff (!rst_b)
		inconsistent |=> inconsistent_aps_alarm)
		else $error("inconsistent not reported");
	AST_MISM_SCOPE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		prot_mode != kam_pkg::KAM_PROT_LIN_1P1 || !bidirectional
		|=> !channel_mismatch_alarm)
		else $error("mismatch outside bidirectional 1+1");
	AST_MISM_CROSSED: assert property (@(posedge ref_clk) disable iff (!rst_b)
		working_active |=> !channel_mismatch_alarm)
		else $error("mismatch while working line active");
	AST_SEVERITY: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$rose(rst_b) ##1 1'b1 |-> mismatch_severity.severity == `KAM_SEV_MAJOR)
		else $error("mismatch severity wrong");

	// ****************************************
	// raise and clear checks
	// ****************************************
	// a cause raises its alarm at the next edge and its absence drops it,
	// so an old frame history can never keep an alarm standing
	AST_FAIL_ON_CODE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		stable && bad_code |=> channel_byte_failure_alarm)
		else $error("invalid request code not flagged");
	AST_FAIL_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!rx_byte_fail && !(stable && bad_code) |=> !channel_byte_failure_alarm)
		else $error("byte failure alarm held without cause");

	AST_DFLT_RAISE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		is_ring && stable && bad_ring_pair |=> default_kbyte_alarm)
		else $error("invalid ring pair not flagged");
	AST_DFLT_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!stable || !bad_ring_pair |=> !default_kbyte_alarm)
		else $error("default k alarm held without cause");

	AST_IMP_UNUSED: assert property (@(posedge ref_clk) disable iff (!rst_b)
		stable && !ext_switch && unused_code |=> improper_code_alarm)
		else $error("unused mode code not flagged");
	AST_IMP_IRRELEVANT: assert property (@(posedge ref_clk) disable iff (!rst_b)
		stable && !ext_switch && irrelevant_code |=> improper_code_alarm)
		else $error("irrelevant code not flagged");
	AST_IMP_UNFIT: assert property (@(posedge ref_clk) disable iff (!rst_b)
		stable && !ext_switch && unfit_ring |=> improper_code_alarm)
		else $error("request unfit for ring not flagged");
	AST_IMP_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!(unused_code || irrelevant_code || unfit_ring || et_unsourced)
		|=> !improper_code_alarm)
		else $error("improper code held without cause");

	AST_INCON_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!inconsistent |=> !inconsistent_aps_alarm)
		else $error("inconsistent held after identical frames");

	AST_MISM_RAISE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		stable && prot_mode == kam_pkg::KAM_PROT_LIN_1P1 && bidirectional &&
		expect_working && protect_rx && !working_active |=> channel_mismatch_alarm)
		else $error("protect channel received but no mismatch");
	AST_MISM_EXPECT: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!expect_working || !protect_rx |=> !channel_mismatch_alarm)
		else $error("mismatch without protect received");
	AST_MISM_CLEAR: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!stable |=> !channel_mismatch_alarm)
		else $error("mismatch held without three frames");

	AST_SEV_STEADY: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(rst_b) |-> mismatch_severity == {`KAM_SEV_MAJOR, 1'b1})
		else $error("mismatch severity not major service-affecting");
	AST_SEV_MINOR: assert property (@(posedge ref_clk) disable iff (!rst_b)
		$past(rst_b) |-> minor_severity == {`KAM_SEV_MINOR, 1'b0})
		else $error("other alarms not minor non-service-affecting");

	COV_MISM: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(channel_mismatch_alarm));
	COV_IMP: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(improper_code_alarm));
	COV_INCON: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(inconsistent_aps_alarm));
	COV_DFLT: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(default_kbyte_alarm));
	COV_FAIL: cover property (@(posedge ref_clk) disable iff (!rst_b) $rose(channel_byte_failure_alarm));
endmodule : kam_monitor

/* File: hdl/kam_defines.svh */
// constants for the k byte alarm monitor
`ifndef KAM_DEFINES_SVH
`define KAM_DEFINES_SVH
`define KAM_PERSIST_FRAMES 2'h3
`define KAM_K2_MODE_MSB 2
`define KAM_K2_MODE_LSB 0
`define KAM_MODE_UNUSED0 3'h0
`define KAM_MODE_ET 3'h3
`define KAM_MODE_RSVD 3'h4
`define KAM_REQ_NONE 4'h0
`define KAM_REQ_SPAN_SF 4'hB
`define KAM_REQ_SPAN_SD 4'h9
`define KAM_REQ_EXER_SPAN 4'h5
`define KAM_REQ_FS_SPAN 4'hF
`define KAM_REQ_INVALID 4'hE
`define KAM_SEV_MINOR 2'h1
`define KAM_SEV_MAJOR 2'h2
`endif

/* File: hdl/kam_pkg.sv */
// types for the k byte alarm monitor
package kam_pkg;
	typedef struct packed {
		logic [7:0] k1;
		logic [7:0] k2;
	} kam_kbytes_t;

	typedef enum logic [1:0] {
		KAM_PROT_NONE,
		KAM_PROT_LIN_1P1,
		KAM_PROT_RING_2F,
		KAM_PROT_RING_4F
	} kam_prot_t;

	typedef struct packed {
		logic byte_fail;
		logic default_k;
		logic improper;
		logic inconsistent;
		logic mismatch;
	} kam_alarms_t;

	typedef struct packed {
		logic [1:0] severity;
		logic service_affecting;
	} kam_sev_t;
endpackage : kam_pkg

/* File: hdl/kam_persist.sv */
// three-frame persistence tracker for received k bytes
`timescale 1ns/100ps
`include "kam_defines.svh"
module kam_persist (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic frame_strobe,
	input wire kam_pkg::kam_kbytes_t kbytes,
	output logic stable,
	output logic inconsistent
);
	kam_pkg::kam_kbytes_t prev;
	logic [1:0] run;
	logic [1:0] seen;
	kam_pkg::kam_kbytes_t next_prev;
	logic [1:0] next_run;
	logic [1:0] next_seen;
	logic next_stable;
	logic next_inconsistent;

	always_comb begin
		next_prev = prev;
		next_run = run;
		next_seen = seen;
		next_stable = stable;
		next_inconsistent = inconsistent;
		if (frame_strobe) begin
			next_prev = kbytes;
			if (seen != `KAM_PERSIST_FRAMES)
				next_seen = seen + 2'h1;
			if (seen != 2'h0 && kbytes == prev) begin
				if (run != `KAM_PERSIST_FRAMES)
					next_run = run + 2'h1;
			end else begin
				next_run = 2'h1;
			end
			// a window of three frames needs three frames on record
			next_stable = (next_run == `KAM_PERSIST_FRAMES);
			next_inconsistent = (next_seen == `KAM_PERSIST_FRAMES) && !next_stable;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev <= '0;
			run <= 2'h0;
			seen <= 2'h0;
			stable <= 1'b0;
			inconsistent <= 1'b0;
		end else begin
			prev <= next_prev;
			run <= next_run;
			seen <= next_seen;
			stable <= next_stable;
			inconsistent <= next_inconsistent;
		end
	end

	AST_STABLE_NEEDS_SAME: assert property (@(posedge ref_clk) disable iff (!rst_b)
		frame_strobe && kbytes != prev |=> !stable)
		else $error("stable set after a changed k byte pair");
	AST_INCON_EXCLUSIVE: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!(stable && inconsistent))
		else $error("stable and inconsistent both set");
endmodule : kam_persist

/* File: sim/kam_upstream.sv */
// upstream node model that sends k1/k2 bytes once per frame
`timescale 1ns/100ps
module kam_upstream (
	input wire logic ref_clk,
	output logic frame_strobe,
	output kam_pkg::kam_kbytes_t kbytes
);
	initial begin
		frame_strobe = 1'b0;
		kbytes = 16'h0000;
	end
	task automatic send(input logic [7:0] k1, input logic [7:0] k2, input int n);
		repeat (n) begin
			@(posedge ref_clk) #1;
			frame_strobe = 1'b1;
			kbytes = {k1, k2};
			@(posedge ref_clk) #1;
			frame_strobe = 1'b0;
			// bytes mean nothing off the strobe, so show the inverse rather than hold them
			kbytes = ~{k1, k2};
		end
	endtask : send
endmodule : kam_upstream

/* File: sim/tb_top.sv */
// self-checking bench for the k byte alarm monitor
`timescale 1ns/100ps
`include "kam_defines.svh"
module tb_top;
	logic ref_clk;
	logic rst_b;
	logic frame_strobe;
	kam_pkg::kam_kbytes_t rx_kbytes;
	logic rx_byte_fail, bidirectional, expect_working, working_active, tx_sourcing_et, ext_switch;
	kam_pkg::kam_prot_t prot_mode;
	logic fail_a, dflt_a, imp_a, inc_a, mis_a;
	kam_pkg::kam_sev_t mismatch_severity, minor_severity;
	int n_mismatch = 0;
	int checks = 0;
	int cycles = 0;
	kam_monitor i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .frame_strobe(frame_strobe),
		.rx_kbytes(rx_kbytes), .rx_byte_fail(rx_byte_fail), .prot_mode(prot_mode),
		.bidirectional(bidirectional), .expect_working(expect_working),
		.working_active(working_active), .tx_sourcing_et(tx_sourcing_et),
		.ext_switch(ext_switch), .channel_byte_failure_alarm(fail_a),
		.default_kbyte_alarm(dflt_a), .improper_code_alarm(imp_a),
		.inconsistent_aps_alarm(inc_a), .channel_mismatch_alarm(mis_a),
		.mismatch_severity(mismatch_severity), .minor_severity(minor_severity));
	kam_upstream i_far (.ref_clk(ref_clk), .frame_strobe(frame_strobe), .kbytes(rx_kbytes));
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end
	// the whole run needs well under a thousand cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_mismatch++;
			end_sim();
		end
	end
	//****************
	// helpers
	//****************
	task automatic end_sim();
		if (n_mismatch == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// alarms in order fail, default, improper, inconsistent, mismatch
	task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] mask);
		logic [4:0] got;
		got = {fail_a, dflt_a, imp_a, inc_a, mis_a} & mask;
		checks++;
		if (got !== (exp & mask)) begin
			n_mismatch++;
			$display("BAD %s expected %b seen %b", what, exp & mask, got);
		end
	endtask : chk
	task automatic chk_sev(input string what, input logic [2:0] exp, input logic [2:0] got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_sev
	// f = bidirectional, expect_working, working_active, tx_sourcing_et, ext_switch, byte fail
	task automatic cfg(input kam_pkg::kam_prot_t p, input logic [5:0] f);
		@(posedge ref_clk) #1;
		prot_mode = p;
		{bidirectional, expect_working, working_active, tx_sourcing_et, ext_switch, rx_byte_fail} = f;
	endtask : cfg
	task automatic run(input logic [7:0] k1, input logic [7:0] k2, input int n);
		i_far.send(k1, k2, n);
		repeat (4) @(posedge ref_clk);
		#2;
	endtask : run
	//****************
	// scenarios
	//****************
	task automatic t_fail();
		cfg(kam_pkg::KAM_PROT_NONE, 6'h01);
		run(8'h00, 8'h01, 3);
		chk("byte_fail", 5'h10, 5'h10);
		cfg(kam_pkg::KAM_PROT_NONE, 6'h00);
		run(8'h00, 8'h01, 3);
		chk("all_clear", 5'h00, 5'h1F);
	endtask : t_fail
	task automatic t_improper();
		cfg(kam_pkg::KAM_PROT_LIN_1P1, 6'h00);
		run(8'h00, 8'h00, 2);
		chk("unused_two", 5'h00, 5'h04);
		run(8'h00, 8'h00, 1);
		chk("unused_0", 5'h04, 5'h04);
		run(8'h00, 8'h04, 3);
		chk("unused_4", 5'h04, 5'h04);
		cfg(kam_pkg::KAM_PROT_LIN_1P1, 6'h02);
		run(8'h00, 8'h04, 0);
		chk("ext_switch", 5'h00, 5'h04);
		cfg(kam_pkg::KAM_PROT_LIN_1P1, 6'h00);
		run(8'h01, 8'h01, 3);
		chk("irrelevant", 5'h04, 5'h04);
		run(8'h00, 8'h03, 3);
		chk("et_unsourced", 5'h04, 5'h04);
		cfg(kam_pkg::KAM_PROT_LIN_1P1, 6'h04);
		run(8'h00, 8'h03, 0);
		chk("et_sourced", 5'h00, 5'h04);
	endtask : t_improper
	task automatic t_ring();
		cfg(kam_pkg::KAM_PROT_RING_2F, 6'h00);
		run(8'hB1, 8'h01, 3);
		chk("span_in_2f", 5'h04, 5'h04);
		cfg(kam_pkg::KAM_PROT_RING_4F, 6'h00);
		run(8'hB1, 8'h01, 0);
		chk("span_in_4f", 5'h00, 5'h04);
		cfg(kam_pkg::KAM_PROT_RING_2F, 6'h00);
		run(8'hE1, 8'h01, 3);
		chk("ring_default", 5'h18, 5'h18);
		cfg(kam_pkg::KAM_PROT_LIN_1P1, 6'h00);
		run(8'hE1, 8'h01, 0);
		chk("lin_default", 5'h00, 5'h08);
	endtask : t_ring
	task automatic t_incon();
		run(8'h00, 8'h01, 1);
		run(8'h00, 8'h02, 1);
		run(8'h00, 8'h05, 1);
		chk("inconsistent", 5'h02, 5'h02);
		run(8'h00, 8'h05, 2);
		chk("consistent", 5'h00, 5'h02);
	endtask : t_incon
	task automatic t_mismatch();
		cfg(kam_pkg::KAM_PROT_LIN_1P1, 6'h30);
		run(8'h00, 8'h11, 3);
		chk("mismatch", 5'h01, 5'h01);
		cfg(kam_pkg::KAM_PROT_LIN_1P1, 6'h10);
		run(8'h00, 8'h11, 0);
		chk("unidirectional", 5'h00, 5'h01);
		cfg(kam_pkg::KAM_PROT_RING_4F, 6'h30);
		run(8'h00, 8'h11, 0);
		chk("ring_no_mismatch", 5'h00, 5'h01);
		cfg(kam_pkg::KAM_PROT_LIN_1P1, 6'h38);
		run(8'h00, 8'h11, 0);
		chk("working_active", 5'h00, 5'h01);
	endtask : t_mismatch
	initial begin
		rst_b = 1'b0;
		{bidirectional, expect_working, working_active, tx_sourcing_et, ext_switch, rx_byte_fail} = 6'h00;
		prot_mode = kam_pkg::KAM_PROT_NONE;
		repeat (2) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		repeat (2) @(posedge ref_clk);
		#2;
		chk_sev("mismatch_severity", {`KAM_SEV_MAJOR, 1'b1}, mismatch_severity);
		chk_sev("minor_severity", {`KAM_SEV_MINOR, 1'b0}, minor_severity);
		t_fail();
		t_improper();
		t_ring();
		t_incon();
		t_mismatch();
		end_sim();
	end
endmodule : tb_top
